// [rtl/acp_config_port.sv]
/*
 * Serial configuration slave of the converter: shift engine on the serial
 * clock, register file on the sample-side system clock.
 * Assumes the serial clock idles low while select_n is high, and that the
 * system clock runs whenever the port is used.
 */
// Function
// R1 - Master keeps serial clock under rate limits.
// R2 - Sample clock runs during every register access.
// R3 - Three-wire default; setup bit 7 enables output.
// R4 - Bus sharing only in three-wire operation.
// R5 - Only one slave selected for reads.
// R6 - First rising edge after select starts instruction.
// R7 - MSB first default; setup bit 6 LSB.
// R8 - Address increments MSB-first, decrements LSB-first.
// R9 - Instruction: direction, length, 13-bit address.
// R10 - Length codes one, two, three, open burst.
// R11 - Data continues while selected and clocked.
// R12 - Select may pause at permitted byte boundaries.
// R13 - Deselect inside long burst data abandons transfer.
// R14 - Setup bit 5 restores configuration defaults.
// R15 - Master mirrors setup nibbles, sets bit 4.
// R16 - Burst ends at deselect or burst end address.
// R17 - Readable die identifier and revision registers.
// R18 - Converter select resets zero; bit 0 selects.
// R19 - Unselected converter reads return fixed error byte.
// R20 - Offset trims are 8-bit codes centred mid.
// R21 - Trims start from calibration results.
// R22 - Coarse gain four additive weighted bits.
// R23 - Medium and fine gains centred 8-bit codes.
// R24 - Data pin driven only during read data; code keeps driving it after the last read byte until deselect.
`include "acp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module acp_config_port #(
	parameter logic [7:0] DIE_ID = 8'h5A,   // Arbitrary value.
	parameter logic [7:0] DIE_REV = 8'h01   // Arbitrary value.
) (
	// System clock and reset.
	input wire logic SYS_CLK_I,
	input wire logic SRST_I,
	// Serial link.
	input wire logic SCLK_I,
	input wire logic SELECT_N_I,
	input wire logic SDIO_I,
	output logic SDIO_O,
	output logic SDIO_OE_O,
	output logic SERIAL_OUT_PIN_O,
	output logic SERIAL_OUT_PIN_OE_O,
	// Calibration results loaded at reset.
	input wire acp_pkg::acp_trims_t CAL_TRIMS_I,
	// Settings to the converter core.
	output acp_pkg::acp_trims_t TRIMS_O,
	output logic CONV_SELECTED_O
);
	import acp_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Reverses a byte for least-significant-bit-first order.
	function automatic logic [7:0] acp_rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			r[i] = v[7 - i];
		end
		return r;
	endfunction : acp_rev8

	// Marks the per-converter trim registers.
	function automatic logic acp_indexed(input logic [12:0] a);
		return (a >= `ACP_ADDR_ZERO_LARGE) && (a <= `ACP_ADDR_SCALE_SMALL);
	endfunction : acp_indexed

	// ----------------------------------------------------------------
	// Link domain: shift engine on the serial clock
	// ----------------------------------------------------------------

	// Configuration bits seen by the link domain, synchronised from sys.
	logic lsb_sync1_reg;
	logic lsb_sync2_reg;
	logic oen_sync1_reg;
	logic oen_sync2_reg;
	logic [7:0] end_sync1_reg;
	logic [7:0] end_sync2_reg;
	// System-side sources; read data stays stable between requests.
	logic lsb_sync_src;
	logic oen_sync_src;
	logic [7:0] end_sync_src;
	logic [7:0] rdata_reg;

	acp_phase_t phase_reg;
	logic [4:0] bit_cnt_reg;
	logic [15:0] shift_reg;
	acp_instr_t instr_reg;
	logic [12:0] addr_reg;
	logic [1:0] left_reg;
	logic [7:0] tx_reg;
	logic drive_reg;
	acp_instr_t instr_word;
	logic instr_end;
	logic byte_end;
	// Request toggles toward sys carry address and data words.
	logic wr_tgl_reg;
	logic rd_tgl_reg;
	logic [12:0] req_addr_reg;
	logic [7:0] req_data_reg;

	logic [15:0] shift_next;
	logic [7:0] byte_in;
	logic [12:0] step_addr;

	// Brings the slow configuration levels into the link domain.
	always_ff @(posedge SCLK_I)
	begin
		lsb_sync1_reg <= lsb_sync_src;
		lsb_sync2_reg <= lsb_sync1_reg;
		oen_sync1_reg <= oen_sync_src;
		oen_sync2_reg <= oen_sync1_reg;
		end_sync1_reg <= end_sync_src;
		end_sync2_reg <= end_sync1_reg;
	end

	// Incoming bit joins the shift word; the byte is re-ordered as needed.
	always_comb
	begin
		shift_next = {shift_reg[14:0], SDIO_I};
		byte_in = lsb_sync2_reg ? acp_rev8(shift_next[7:0]) :
			shift_next[7:0]; // R7
		step_addr = lsb_sync2_reg ? addr_reg - 13'd1 : addr_reg + 13'd1; // R8
		instr_word = acp_instr_t'(lsb_sync2_reg ? {acp_rev8(shift_next[15:8]),
			acp_rev8(shift_next[7:0])} : shift_next); // R9
		instr_end = phase_reg == ACP_INSTR &&
			bit_cnt_reg == `ACP_INSTR_BITS - 5'd1;
		byte_end = phase_reg == ACP_DATA &&
			bit_cnt_reg == `ACP_BYTE_BITS - 5'd1;
	end

	// Each finished read instruction or data byte hands one request to the system.
	always_ff @(posedge SCLK_I or posedge SRST_I)
	begin
		if (SRST_I)
		begin
			wr_tgl_reg <= 1'b0;
			rd_tgl_reg <= 1'b0;
			req_addr_reg <= 13'h0000;
			req_data_reg <= 8'h00;
		end
		else if (instr_end && instr_word.is_read)
		begin
			req_addr_reg <= instr_word.address;
			rd_tgl_reg <= ~rd_tgl_reg;
		end
		else if (byte_end && instr_reg.is_read)
		begin
			req_addr_reg <= step_addr; // R8
			rd_tgl_reg <= ~rd_tgl_reg;
		end
		else if (byte_end)
		begin
			req_addr_reg <= addr_reg;
			req_data_reg <= byte_in;
			wr_tgl_reg <= ~wr_tgl_reg;
		end
	end

	// The engine restarts when select rises unless a counted transfer pauses; it holds no clock edge
	// across a deselected gap except inside the instruction header, whose bit count is kept.
	always_ff @(posedge SCLK_I or posedge SELECT_N_I)
	begin
		if (SELECT_N_I)
		begin
			drive_reg <= 1'b0; // R24
			case (phase_reg)
				ACP_INSTR: phase_reg <= ACP_INSTR; // R12
				ACP_DATA:
				begin
					if (instr_reg.length == `ACP_LEN_OPEN)
					begin
						phase_reg <= ACP_INSTR; // R13
					end
					bit_cnt_reg <= 5'd0; // R12
				end
				default:
				begin
					phase_reg <= ACP_INSTR; // R16
					bit_cnt_reg <= 5'd0;
				end
			endcase
		end
		else
		begin
			shift_reg <= shift_next; // R6
			bit_cnt_reg <= bit_cnt_reg + 5'd1;
			case (phase_reg)
				ACP_INSTR:
				begin
					if (bit_cnt_reg == `ACP_INSTR_BITS - 5'd1)
					begin
						instr_reg <= instr_word; // R9
						addr_reg <= instr_word.address;
						left_reg <= instr_word.length; // R10
						phase_reg <= ACP_DATA;
						bit_cnt_reg <= 5'd0;
					end
				end
				ACP_DATA:
				begin
					drive_reg <= instr_reg.is_read; // R24
					if (bit_cnt_reg == `ACP_BYTE_BITS - 5'd1)
					begin
						bit_cnt_reg <= 5'd0;
						addr_reg <= step_addr; // R8
						// Counted lengths stop; open bursts run on to the end
						// address or to deselect.
						if (instr_reg.length != `ACP_LEN_OPEN)
						begin
							if (left_reg == `ACP_COUNT_ONE)
							begin
								phase_reg <= ACP_DONE;
							end
							left_reg <= left_reg - 2'd1;
						end
						else if (addr_reg[7:0] == end_sync2_reg)
						begin
							phase_reg <= ACP_DONE; // R16
						end
					end // R11
				end
				ACP_DONE:
				begin
					bit_cnt_reg <= 5'd0;
				end
				default:
				begin
					phase_reg <= ACP_INSTR;
				end
			endcase
		end
	end

	// Read byte is shifted out on falling edges in the chosen order.
	always_ff @(negedge SCLK_I)
	begin
		// Loaded after the first data rise; the slow link guarantees the
		// word settled in the system domain long before this edge.
		if (phase_reg == ACP_DATA && bit_cnt_reg == 5'd1)
		begin
			tx_reg <= lsb_sync2_reg ? acp_rev8(rdata_reg) : rdata_reg; // R7
		end
		else
		begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	// Pin drivers: four-wire uses the output pin, else the data pin.
	always_comb
	begin
		SDIO_O = tx_reg[7];
		SDIO_OE_O = drive_reg && !oen_sync2_reg && !SELECT_N_I; // R3 R24
		SERIAL_OUT_PIN_O = tx_reg[7];
		SERIAL_OUT_PIN_OE_O = oen_sync_src; // R3
	end

	// ----------------------------------------------------------------
	// System domain: register file
	// ----------------------------------------------------------------

	logic [7:0] port_setup_reg;
	logic [7:0] burst_last_reg;
	logic [7:0] conv_sel_reg;
	acp_trims_t trims_reg;
	logic [2:0] wr_sync_reg;
	logic [2:0] rd_sync_reg;
	logic wr_evt;
	logic rd_evt;
	logic [7:0] rd_value;

	assign lsb_sync_src = port_setup_reg[`ACP_BIT_LSB_FIRST];
	assign oen_sync_src = port_setup_reg[`ACP_BIT_OUT_PIN_EN];
	assign end_sync_src = burst_last_reg;

	// Toggle crossings; address changes with each toggle, data with each write toggle, and both hold while it crosses.
	always_ff @(posedge SYS_CLK_I)
	begin
		if (SRST_I)
		begin
			wr_sync_reg <= 3'b000;
			rd_sync_reg <= 3'b000;
		end
		else
		begin
			wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
			rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
		end
	end
	assign wr_evt = wr_sync_reg[2] ^ wr_sync_reg[1];
	assign rd_evt = rd_sync_reg[2] ^ rd_sync_reg[1];

	// Read mux, with the fixed error byte for unselected trims.
	always_comb
	begin
		case (req_addr_reg)
			`ACP_ADDR_PORT_SETUP: rd_value = port_setup_reg;
			`ACP_ADDR_BURST_LAST: rd_value = burst_last_reg;
			`ACP_ADDR_DIE_ID: rd_value = DIE_ID; // R17
			`ACP_ADDR_DIE_REV: rd_value = DIE_REV; // R17
			`ACP_ADDR_CONV_SEL: rd_value = conv_sel_reg;
			`ACP_ADDR_ZERO_LARGE: rd_value = trims_reg.zero_large; // R20
			`ACP_ADDR_ZERO_SMALL: rd_value = trims_reg.zero_small;
			`ACP_ADDR_SCALE_LARGE: rd_value = {4'h0, trims_reg.scale_large};
			`ACP_ADDR_SCALE_MID: rd_value = trims_reg.scale_mid; // R23
			`ACP_ADDR_SCALE_SMALL: rd_value = trims_reg.scale_small;
			default: rd_value = `ACP_UNMAPPED_READ;
		endcase
		if (acp_indexed(req_addr_reg) && !conv_sel_reg[`ACP_BIT_SELECT_CONV])
		begin
			rd_value = `ACP_NO_CONV_ERR; // R19
		end
	end

	// Captures the read byte for the link domain.
	always_ff @(posedge SYS_CLK_I)
	begin
		if (SRST_I)
		begin
			rdata_reg <= 8'h00;
		end
		else if (rd_evt)
		begin
			rdata_reg <= rd_value;
		end
	end

	// Port configuration, burst end and soft reset.
	always_ff @(posedge SYS_CLK_I)
	begin
		if (SRST_I)
		begin
			port_setup_reg <= `ACP_RST_PORT_SETUP; // R3 R7
			burst_last_reg <= `ACP_RST_BURST_LAST;
			conv_sel_reg <= `ACP_RST_CONV_SEL; // R18
		end
		else if (wr_evt)
		begin
			if (req_addr_reg == `ACP_ADDR_PORT_SETUP &&
				req_data_reg[`ACP_BIT_SOFT_RESET])
			begin
				port_setup_reg <= `ACP_RST_PORT_SETUP; // R14
				burst_last_reg <= `ACP_RST_BURST_LAST;
				conv_sel_reg <= `ACP_RST_CONV_SEL;
			end
			else if (req_addr_reg == `ACP_ADDR_PORT_SETUP)
			begin
				port_setup_reg <= req_data_reg;
			end
			else if (req_addr_reg == `ACP_ADDR_BURST_LAST)
			begin
				burst_last_reg <= req_data_reg; // R16
			end
			else if (req_addr_reg == `ACP_ADDR_CONV_SEL)
			begin
				conv_sel_reg <= req_data_reg; // R18
			end
		end
	end

	// Trims load calibration results at reset; writes need a converter.
	always_ff @(posedge SYS_CLK_I)
	begin
		if (SRST_I)
		begin
			trims_reg <= CAL_TRIMS_I; // R21
		end
		else if (wr_evt && conv_sel_reg[`ACP_BIT_SELECT_CONV])
		begin
			case (req_addr_reg)
				`ACP_ADDR_ZERO_LARGE: trims_reg.zero_large <= req_data_reg;
				`ACP_ADDR_ZERO_SMALL: trims_reg.zero_small <= req_data_reg;
				`ACP_ADDR_SCALE_LARGE: trims_reg.scale_large <= req_data_reg[3:0]; // R22
				`ACP_ADDR_SCALE_MID: trims_reg.scale_mid <= req_data_reg;
				`ACP_ADDR_SCALE_SMALL: trims_reg.scale_small <= req_data_reg;
				default: trims_reg <= trims_reg;
			endcase
		end
	end

	// Core-facing outputs.
	assign TRIMS_O = trims_reg;
	assign CONV_SELECTED_O = conv_sel_reg[`ACP_BIT_SELECT_CONV];

endmodule : acp_config_port

`default_nettype wire

// [rtl/acp_defs.svh]
/*
 * Offsets, field positions, reset values and fixed codes for the serial
 * configuration port of the converter.
 * Assumes it is included by its bare name from rtl/ files only.
 */
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH

// Register byte addresses.
`define ACP_ADDR_PORT_SETUP 13'h0000
`define ACP_ADDR_BURST_LAST 13'h0002
`define ACP_ADDR_DIE_ID 13'h0008
`define ACP_ADDR_DIE_REV 13'h0009
`define ACP_ADDR_CONV_SEL 13'h0010
`define ACP_ADDR_ZERO_LARGE 13'h0020
`define ACP_ADDR_ZERO_SMALL 13'h0021
`define ACP_ADDR_SCALE_LARGE 13'h0022
`define ACP_ADDR_SCALE_MID 13'h0023
`define ACP_ADDR_SCALE_SMALL 13'h0024

// Port setup and converter select field positions.
`define ACP_BIT_OUT_PIN_EN 7
`define ACP_BIT_LSB_FIRST 6
`define ACP_BIT_SOFT_RESET 5
`define ACP_BIT_SELECT_CONV 0

// Reset values and fixed answers.
`define ACP_RST_PORT_SETUP 8'h18
`define ACP_RST_BURST_LAST 8'hFF
`define ACP_RST_CONV_SEL 8'h00
`define ACP_TRIM_MID 8'h80
`define ACP_NO_CONV_ERR 8'hAD
`define ACP_UNMAPPED_READ 8'h00

// Serial framing counts.
`define ACP_INSTR_BITS 5'd16
`define ACP_BYTE_BITS 5'd8
`define ACP_LEN_OPEN 2'b11
`define ACP_COUNT_ONE 2'b00

`endif

// [rtl/acp_pkg.sv]
/*
 * Types shared by the serial configuration port.
 * Assumes acp_defs.svh supplies all numeric constants.
 */
package acp_pkg;

	// Decoded instruction word.
	typedef struct packed {
		logic is_read;
		logic [1:0] length;
		logic [12:0] address;
	} acp_instr_t;

	// Trim settings presented to the converter core.
	typedef struct packed {
		logic [7:0] zero_large;
		logic [7:0] zero_small;
		logic [3:0] scale_large;
		logic [7:0] scale_mid;
		logic [7:0] scale_small;
	} acp_trims_t;

	// Serial engine phases.
	typedef enum logic [1:0] {
		ACP_INSTR,
		ACP_DATA,
		ACP_DONE
	} acp_phase_t;

endpackage : acp_pkg

// [bench/acp_config_port_checker.sv]
/* Pin checker of the configuration port, bound at its top module.
 * Assumes link addresses stay below 0x100. */
`timescale 1ns/100ps
`default_nettype none

module acp_config_port_checker (
	// Clocks and reset.
	input wire logic SYS_CLK_I,
	input wire logic SRST_I,
	input wire logic SCLK_I,
	// Link pins.
	input wire logic SELECT_N_I,
	input wire logic SDIO_I,
	input wire logic SDIO_O,
	input wire logic SDIO_OE_O,
	input wire logic SERIAL_OUT_PIN_O,
	input wire logic SERIAL_OUT_PIN_OE_O,
	// Trims.
	input wire acp_pkg::acp_trims_t CAL_TRIMS_I,
	input wire acp_pkg::acp_trims_t TRIMS_O,
	input wire logic CONV_SELECTED_O
);
	import acp_pkg::*;
	logic [4:0] cnt;
	logic rd_seen;

	// Counts link edges; the read flag is caught at both ends of byte one.
	always_ff @(posedge SCLK_I or posedge SELECT_N_I)
	begin
		if (SELECT_N_I)
		begin
			cnt <= 5'h00;
			rd_seen <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == 5'h1F) ? cnt : cnt + 5'h01;
			rd_seen <= rd_seen | (SDIO_I & (cnt == 5'h00 || cnt == 5'h07));
		end
	end

	oe_idle_a: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
		SELECT_N_I && $past(SELECT_N_I) |-> !SDIO_OE_O) else $error("Pin busy.");
	instr_free_a: assert property (@(posedge SCLK_I) disable iff (SELECT_N_I)
		cnt < 5'h10 |-> !SDIO_OE_O) else $error("Pin driven in header.");
	write_free_a: assert property (@(posedge SCLK_I) disable iff (SELECT_N_I)
		cnt > 5'h10 && !rd_seen |-> !SDIO_OE_O) else $error("Pin driven in write.");
	read_drive_a: assert property (@(posedge SCLK_I) disable iff (SELECT_N_I)
		cnt > 5'h10 && rd_seen && !SERIAL_OUT_PIN_OE_O |-> SDIO_OE_O)
		else $error("Pin idle in read.");
	four_wire_a: assert property (@(posedge SCLK_I) disable iff (SELECT_N_I)
		SERIAL_OUT_PIN_OE_O |-> !SDIO_OE_O && SERIAL_OUT_PIN_O == SDIO_O)
		else $error("Output pin mismatch.");
	reset_vals_a: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
		$fell(SRST_I) |-> TRIMS_O == CAL_TRIMS_I && !CONV_SELECTED_O
		&& !SERIAL_OUT_PIN_OE_O) else $error("Bad reset values.");
	trims_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
		!CONV_SELECTED_O && !$past(CONV_SELECTED_O) |-> $stable(TRIMS_O))
		else $error("Trims moved unselected.");
	cfg_latch_a: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
		$changed(CONV_SELECTED_O) || $changed(SERIAL_OUT_PIN_OE_O) |-> !SELECT_N_I)
		else $error("Setting moved off link.");
endmodule : acp_config_port_checker

bind acp_config_port acp_config_port_checker u_chk (
	.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .SCLK_I(SCLK_I),
	.SELECT_N_I(SELECT_N_I), .SDIO_I(SDIO_I), .SDIO_O(SDIO_O),
	.SDIO_OE_O(SDIO_OE_O), .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O),
	.SERIAL_OUT_PIN_OE_O(SERIAL_OUT_PIN_OE_O), .CAL_TRIMS_I(CAL_TRIMS_I),
	.TRIMS_O(TRIMS_O), .CONV_SELECTED_O(CONV_SELECTED_O));
`default_nettype wire

// [bench/acp_spi_master.sv]
/* Behavioural link master for the configuration port.
 * Assumes the bench resolves the data pin and runs one xfer at a time. */
`timescale 1ns/100ps
`default_nettype none

module acp_spi_master (
	// Link pins.
	output logic sclk_o,
	output logic select_n_o,
	output logic mosi_o,
	output logic mosi_oe_o,
	input wire logic sdio_i,
	input wire logic sdo_i,
	// Read bytes.
	output logic rd_valid_o,
	output logic [7:0] rd_byte_o
);
	logic lsb_first = 1'b0;
	logic four_wire = 1'b0;
	logic smp;
	logic [7:0] wq[$];

	// Clock rests low while deselected.
	initial
	begin
		sclk_o = 1'b0;
		select_n_o = 1'b1;
		mosi_o = 1'b0;
		mosi_oe_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_byte_o = 8'h00;
		// A clock-free select pulse puts the port's engine in a known state.
		#20 select_n_o = 1'b0;
		#20 select_n_o = 1'b1;
	end

	// One bit; the sample taken holds what the previous fall shifted out.
	task automatic clk_bit(input logic b);
		begin
			mosi_o = b;
			#24 smp = four_wire ? sdo_i : sdio_i;
			sclk_o = 1'b1;
			#24 sclk_o = 1'b0;
		end
	endtask : clk_bit

	// Header, then n bytes; cut deselects before that data bit.
	task automatic xfer(input logic rd, input logic [1:0] len,
		input logic [7:0] adr, input int n, input int cut);
		logic [15:0] ins;
		logic [7:0] b;
		logic [7:0] r;
		begin
			ins = {rd, len, 5'h00, adr};
			select_n_o = 1'b0;
			mosi_oe_o = 1'b1;
			#50;
			for (int i = 0; i < 16; i++)
				clk_bit(ins[lsb_first ? i ^ 8 : 15 - i]);
			for (int j = 0; j < n; j++)
			begin
				#1000;
				b = rd ? 8'h00 : wq.pop_front();
				mosi_oe_o = !rd;
				for (int i = 0; i <= 8; i++)
				begin
					if (j * 8 + i == cut)
					begin
						select_n_o = 1'b1;
						mosi_oe_o = 1'b0;
						#500;
						return;
					end
					if (i < 8)
						clk_bit(b[lsb_first ? i : 7 - i]);
					else
						#24 smp = four_wire ? sdo_i : sdio_i;
					if (i > 0)
						r = lsb_first ? {smp, r[7:1]} : {r[6:0], smp};
				end
				rd_byte_o = r;
				rd_valid_o = rd;
				#1 rd_valid_o = 1'b0;
			end
			#1000 select_n_o = 1'b1;
			mosi_oe_o = 1'b0;
			#500;
		end
	endtask : xfer
endmodule : acp_spi_master
`default_nettype wire

// [bench/acp_config_port_tb_top.sv]
/* Self-checking bench of the configuration port.
 * Assumes the design, checker and link master are compiled first. */
`timescale 1ns/100ps
`default_nettype none

module acp_config_port_tb_top;
	import acp_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic flt = 1'b0;
	logic sclk, sel_n, mosi, mosi_oe, sdio_o, sdio_oe, sdo_o, sdo_oe;
	logic conv_sel, rd_valid;
	logic [7:0] rd_byte, mon_exp;
	logic [7:0] exp_q[$];
	logic [7:0] v[5];
	logic [31:0] seed = 32'h96B2;
	acp_trims_t cal = {4'h9, 32'h96B2}, trims;
	int n_mismatch = 0;
	int n_tests = 0;
	wire logic sdio;
	wire logic serial_out_pin;

	// Clock, and the pins as seen by all parties; a free data pin toggles, a free output pin reads high.
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) flt <= ~flt;
	assign sdio = sdio_oe ? sdio_o : (mosi_oe ? mosi : flt);
	assign serial_out_pin = sdo_oe ? sdo_o : 1'b1;

	acp_config_port DUT (
		.SYS_CLK_I(sys_clk), .SRST_I(srst), .SCLK_I(sclk),
		.SELECT_N_I(sel_n), .SDIO_I(sdio), .SDIO_O(sdio_o),
		.SDIO_OE_O(sdio_oe), .SERIAL_OUT_PIN_O(sdo_o),
		.SERIAL_OUT_PIN_OE_O(sdo_oe), .CAL_TRIMS_I(cal),
		.TRIMS_O(trims), .CONV_SELECTED_O(conv_sel));
	acp_spi_master m (
		.sclk_o(sclk), .select_n_o(sel_n), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
		.sdio_i(sdio), .sdo_i(serial_out_pin), .rd_valid_o(rd_valid), .rd_byte_o(rd_byte));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Queues the expected bytes, then reads them.
	task automatic rd(input logic [1:0] len, input logic [7:0] a,
		input logic [7:0] e[$]);
		begin
			foreach (e[k]) exp_q.push_back(e[k]);
			m.xfer(1'b1, len, a, e.size(), -1);
		end
	endtask : rd

	task automatic wr(input logic [1:0] len, input logic [7:0] a,
		input logic [7:0] d[$], input int cut);
		begin
			m.wq = d;
			m.xfer(1'b0, len, a, d.size(), cut);
		end
	endtask : wr

	task automatic final_report;
		begin
			if (exp_q.size() != 0)
				n_mismatch++;
			if (n_mismatch == 0 && n_tests > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask : final_report

	// Each read byte is matched with the oldest expected one.
	always @(posedge rd_valid)
	begin
		n_tests++;
		mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
		if (rd_byte !== mon_exp)
		begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, rd_byte, mon_exp);
		end
	end

	// Main sequence.
	initial
	begin
		repeat (16) @(posedge sys_clk);
		#5 srst = 1'b0;
		repeat (8) @(posedge sys_clk);
		rd(2'b10, 8'h00, '{8'h18, 8'h00, 8'hFF});
		rd(2'b11, 8'h08, '{8'h5A, 8'h01, 8'h00, 8'h00});
		rd(2'b10, 8'h20, '{8'hAD, 8'hAD, 8'hAD});
		wr(2'b00, 8'h20, '{8'h33}, -1);
		wr(2'b00, 8'h10, '{8'h01}, -1);
		rd(2'b11, 8'h20, '{cal.zero_large, cal.zero_small,
			{4'h0, cal.scale_large}, cal.scale_mid, cal.scale_small});
		for (int k = 0; k < 5; k++)
		begin
			seed = lfsr(seed);
			v[k] = (k == 2) ? {4'h0, seed[3:0]} : seed[7:0];
		end
		wr(2'b11, 8'h20, '{v[0], v[1], v[2], v[3], v[4]}, -1);
		rd(2'b11, 8'h20, '{v[0], v[1], v[2], v[3], v[4]});
		wr(2'b11, 8'h23, '{8'hC3, 8'h3C}, 12);
		rd(2'b01, 8'h23, '{8'hC3, v[4]});
		wr(2'b00, 8'h02, '{8'h21}, -1);
		wr(2'b11, 8'h20, '{8'h11, 8'h22, 8'h07}, -1);
		rd(2'b10, 8'h20, '{8'h11, 8'h22, v[2]});
		wr(2'b00, 8'h00, '{8'h5A}, -1);
		m.lsb_first = 1'b1;
		rd(2'b01, 8'h24, '{v[4], 8'hC3});
		wr(2'b00, 8'h00, '{8'h3C}, -1);
		m.lsb_first = 1'b0;
		rd(2'b10, 8'h00, '{8'h18, 8'h00, 8'hFF});
		wr(2'b00, 8'h00, '{8'h99}, -1);
		m.four_wire = 1'b1;
		rd(2'b00, 8'h09, '{8'h01});
		final_report();
	end

	// Watchdog well beyond the expected run of about 100 us.
	initial
	begin
		#500000;
		n_mismatch++;
		final_report();
	end
endmodule : acp_config_port_tb_top
`default_nettype wire
